// File: src/dtr_pkg.sv
// Shared constants and types for the dual timer register front end
package dtr_pkg;
    // Instance bases and the 64-byte window each instance decodes
    localparam logic [31:0] DTR_BASE_FIRST = 32'h40d00000;
    localparam logic [31:0] DTR_BASE_SECOND = 32'h40e00000;
    localparam int DTR_WIN_LSB = 6;
    localparam int DTR_INSTANCES = 2;

    // Byte offsets inside one instance window
    localparam logic [5:0] DTR_OFS_CNT1 = 6'h00;
    localparam logic [5:0] DTR_OFS_CRA = 6'h04;
    localparam logic [5:0] DTR_OFS_CRB = 6'h08;
    localparam logic [5:0] DTR_OFS_CNT2 = 6'h0c;
    localparam logic [5:0] DTR_OFS_DIV = 6'h10;
    localparam logic [5:0] DTR_OFS_CKSRC = 6'h14;
    localparam logic [5:0] DTR_OFS_MODE = 6'h18;
    localparam logic [5:0] DTR_OFS_IRQEN = 6'h1c;
    localparam logic [5:0] DTR_OFS_IRQCLR = 6'h20;
    localparam logic [5:0] DTR_OFS_LAST = DTR_OFS_IRQCLR;

    // Value registers: four 16-bit slots per instance
    localparam int DTR_VAL_W = 16;
    localparam int DTR_SLOTS = 4;
    localparam int DTR_WORDS = DTR_INSTANCES * DTR_SLOTS;
    localparam int DTR_IDX_W = 3;

    // Stored widths of the configuration registers
    localparam int DTR_DIV_W = 8;
    localparam int DTR_CKSRC_W = 6;
    localparam int DTR_MODE_W = 8;
    localparam int DTR_IRQEN_W = 8;
    localparam int DTR_IRQCLR_W = 8;
    localparam int DTR_MODE_EN_BIT = 6;
    localparam logic [7:0] DTR_CFG_RST = 8'h00;
    localparam logic [31:0] DTR_RDATA_NONE = 32'h00000000;

    // AHB-Lite encodings
    localparam logic [1:0] DTR_HTRANS_NONSEQ = 2'h2;
    localparam logic DTR_HRESP_OKAY = 1'b0;

    typedef enum logic [3:0] {
        DTR_BUS_IDLE = 4'h1,
        DTR_BUS_WRITE = 4'h2,
        DTR_BUS_RDWAIT = 4'h4,
        DTR_BUS_RDDONE = 4'h8
    } dtr_bus_state_type;
endpackage

// File: src/dtr_store_if.sv
// Carrier between the bus front end and the value store
`timescale 1ns/1ps
interface dtr_store_if;
    import dtr_pkg::*;
    logic wr_en;
    logic [DTR_IDX_W-1:0] wr_idx;
    logic [DTR_VAL_W-1:0] wr_data;
    logic [DTR_WORDS-1:0] hw_we;
    logic [DTR_WORDS-1:0][DTR_VAL_W-1:0] hw_data;
    logic rd_en;
    logic [DTR_IDX_W-1:0] rd_idx;
    logic [DTR_VAL_W-1:0] rd_data;
    logic [DTR_WORDS-1:0][DTR_VAL_W-1:0] words;

    modport ctrl (
        output wr_en, wr_idx, wr_data, hw_we, hw_data, rd_en, rd_idx,
        input rd_data, words
    );
    modport store (
        input wr_en, wr_idx, wr_data, hw_we, hw_data, rd_en, rd_idx,
        output rd_data, words
    );
endinterface

// File: src/dtr_value_store.sv
// Counter and capture/reload storage for both instances, registered read port
`timescale 1ns/1ps
module dtr_value_store (
    input wire logic hclk,
    input wire logic hresetn,
    dtr_store_if.store vals
);
    import dtr_pkg::*;

    // No reset on the words: contents survive reset and are random at power-up
    always_ff @(posedge hclk) begin // R12
        for (int i = 0; i < DTR_WORDS; i++) begin
            // Software write wins over a same-cycle timer load
            if (vals.wr_en && (vals.wr_idx == DTR_IDX_W'(i))) begin
                vals.words[i] <= vals.wr_data;
            end else if (vals.hw_we[i]) begin
                vals.words[i] <= vals.hw_data[i];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vals.rd_data <= '0;
        end else if (vals.rd_en) begin
            vals.rd_data <= vals.words[vals.rd_idx];
        end
    end
endmodule

// File: src/dtr_timer_regs.sv
// AHB-Lite register front end of the dual 16-bit multifunction timer
//
// Functional notes
// R1: two identical instances at two fixed bases
// R2: nine word registers per instance, fixed order
// R3: counter one is 16 bits, upper reserved
// R4: counter one read returns live count
// R5: counter one writes only while unit enabled
// R6: capture/reload A readable at any time
// R7: capture/reload A written only while enabled
// R8: capture/reload B readable at any time
// R9: capture/reload B written only while enabled
// R10: counter two 16 bits, live read
// R11: counter two writes only while enabled
// R12: reset leaves counters and captures unchanged
// R13: reserved bits read zero, writes ignored
`timescale 1ns/1ps
module dtr_timer_regs #(
    parameter logic [31:0] FIRST_BASE = dtr_pkg::DTR_BASE_FIRST,
    parameter logic [31:0] SECOND_BASE = dtr_pkg::DTR_BASE_SECOND
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [dtr_pkg::DTR_WORDS-1:0] hw_load,
    input wire logic [dtr_pkg::DTR_WORDS-1:0][dtr_pkg::DTR_VAL_W-1:0] hw_value,
    output logic [dtr_pkg::DTR_WORDS-1:0][dtr_pkg::DTR_VAL_W-1:0] value_word,
    output logic [dtr_pkg::DTR_INSTANCES-1:0] timer_unit_enable,
    output logic [dtr_pkg::DTR_INSTANCES-1:0][dtr_pkg::DTR_DIV_W-1:0] clock_divider,
    output logic [dtr_pkg::DTR_INSTANCES-1:0][dtr_pkg::DTR_CKSRC_W-1:0] clock_source_control,
    output logic [dtr_pkg::DTR_INSTANCES-1:0][dtr_pkg::DTR_MODE_W-1:0] operating_mode_control,
    output logic [dtr_pkg::DTR_INSTANCES-1:0][dtr_pkg::DTR_IRQEN_W-1:0] irq_enable_control,
    output logic [dtr_pkg::DTR_INSTANCES-1:0][dtr_pkg::DTR_IRQCLR_W-1:0] irq_flag_clear
);
    import dtr_pkg::*;

    // Address decode shared by the address phase and the checks
    function automatic logic in_window(input logic [31:0] a, input logic [31:0] base);
        in_window = (a[31:DTR_WIN_LSB] == base[31:DTR_WIN_LSB]);
    endfunction

    function automatic logic decode_hit(input logic [31:0] a);
        decode_hit = (in_window(a, FIRST_BASE) || in_window(a, SECOND_BASE))
            && (a[DTR_WIN_LSB-1:0] <= DTR_OFS_LAST) && (a[1:0] == 2'h0); // R2
    endfunction

    function automatic logic is_value_slot(input logic [5:0] ofs);
        is_value_slot = (ofs <= DTR_OFS_CNT2);
    endfunction

    function automatic logic [DTR_IDX_W-1:0] slot_index(input logic inst,
                                                       input logic [5:0] ofs);
        slot_index = {inst, ofs[3:2]};
    endfunction

    dtr_store_if vals ();

    dtr_value_store u_store (
        .hclk(hclk),
        .hresetn(hresetn),
        .vals(vals)
    );

    dtr_bus_state_type state;
    dtr_bus_state_type next_state;
    logic accept;
    logic hit_q;
    logic inst_q;
    logic [5:0] ofs_q;
    logic [31:0] cfg_rdata;
    logic store_sel;
    logic commit;

    assign accept = hsel && hready && (htrans == DTR_HTRANS_NONSEQ || htrans[1]);
    assign hresp = DTR_HRESP_OKAY;
    // Reads take one wait state so a write just before is already visible
    assign hreadyout = (state != DTR_BUS_RDWAIT);
    assign commit = (state == DTR_BUS_WRITE) && hit_q;

    always_comb begin
        next_state = state;
        case (state)
            DTR_BUS_IDLE, DTR_BUS_WRITE, DTR_BUS_RDDONE: begin
                if (accept) begin
                    next_state = hwrite ? DTR_BUS_WRITE : DTR_BUS_RDWAIT;
                end else begin
                    next_state = DTR_BUS_IDLE;
                end
            end
            DTR_BUS_RDWAIT: begin
                next_state = DTR_BUS_RDDONE;
            end
            default: begin
                next_state = DTR_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= DTR_BUS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hit_q <= 1'b0;
            inst_q <= 1'b0;
            ofs_q <= DTR_OFS_CNT1;
        end else if (accept) begin
            hit_q <= decode_hit(haddr);
            inst_q <= in_window(haddr, SECOND_BASE); // R1
            ofs_q <= haddr[DTR_WIN_LSB-1:0];
        end
    end

    // Configuration registers, one set per instance
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < DTR_INSTANCES; i++) begin
                clock_divider[i] <= DTR_CFG_RST[DTR_DIV_W-1:0];
                clock_source_control[i] <= DTR_CFG_RST[DTR_CKSRC_W-1:0];
                operating_mode_control[i] <= DTR_CFG_RST[DTR_MODE_W-1:0];
                irq_enable_control[i] <= DTR_CFG_RST[DTR_IRQEN_W-1:0];
                irq_flag_clear[i] <= DTR_CFG_RST[DTR_IRQCLR_W-1:0];
            end
        end else if (commit) begin
            // Only the implemented low bits are stored
            case (ofs_q) // R13
                DTR_OFS_DIV: clock_divider[inst_q] <= hwdata[DTR_DIV_W-1:0];
                DTR_OFS_CKSRC: clock_source_control[inst_q] <= hwdata[DTR_CKSRC_W-1:0];
                DTR_OFS_MODE: operating_mode_control[inst_q] <= hwdata[DTR_MODE_W-1:0];
                DTR_OFS_IRQEN: irq_enable_control[inst_q] <= hwdata[DTR_IRQEN_W-1:0];
                DTR_OFS_IRQCLR: irq_flag_clear[inst_q] <= hwdata[DTR_IRQCLR_W-1:0];
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        for (int i = 0; i < DTR_INSTANCES; i++) begin
            timer_unit_enable[i] = operating_mode_control[i][DTR_MODE_EN_BIT];
        end
    end

    // Value store hookup; writes gated by the owning instance's enable
    assign vals.wr_en = commit && is_value_slot(ofs_q)
        && timer_unit_enable[inst_q]; // R5 R7 R9 R11
    assign vals.wr_idx = slot_index(inst_q, ofs_q);
    assign vals.wr_data = hwdata[DTR_VAL_W-1:0]; // R3 R13
    assign vals.hw_we = hw_load;
    assign vals.hw_data = hw_value;
    // Read path ignores the enable so captures stay readable
    assign vals.rd_en = (state == DTR_BUS_RDWAIT); // R4 R6 R8 R10
    assign vals.rd_idx = slot_index(inst_q, ofs_q);
    assign value_word = vals.words;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_rdata <= DTR_RDATA_NONE;
            store_sel <= 1'b0;
        end else if (state == DTR_BUS_RDWAIT) begin
            store_sel <= hit_q && is_value_slot(ofs_q);
            cfg_rdata <= DTR_RDATA_NONE;
            if (hit_q) begin
                case (ofs_q) // R13
                    DTR_OFS_DIV: cfg_rdata <= 32'(clock_divider[inst_q]);
                    DTR_OFS_CKSRC: cfg_rdata <= 32'(clock_source_control[inst_q]);
                    DTR_OFS_MODE: cfg_rdata <= 32'(operating_mode_control[inst_q]);
                    DTR_OFS_IRQEN: cfg_rdata <= 32'(irq_enable_control[inst_q]);
                    DTR_OFS_IRQCLR: cfg_rdata <= 32'(irq_flag_clear[inst_q]);
                    default: cfg_rdata <= DTR_RDATA_NONE;
                endcase
            end
        end
    end

    // Upper half of a value register always reads zero
    always_comb begin
        if (state != DTR_BUS_RDDONE) begin
            hrdata = DTR_RDATA_NONE;
        end else if (store_sel) begin
            hrdata = 32'(vals.rd_data); // R3 R13
        end else begin
            hrdata = cfg_rdata;
        end
    end

    // Checks
    logic [DTR_VAL_W-1:0] wr_word_now;
    logic [DTR_VAL_W-1:0] rd_word_now;
    assign wr_word_now = vals.words[vals.wr_idx];
    assign rd_word_now = vals.words[vals.rd_idx];

    sequence read_accept_s;
        accept && !hwrite;
    endsequence

    sequence read_answer_s;
        ##1 !hreadyout ##1 hreadyout && (state == DTR_BUS_RDDONE);
    endsequence

    property read_timing_p;
        @(posedge hclk) disable iff (!hresetn) read_accept_s |-> read_answer_s;
    endproperty

    read_one_wait_a: assert property (read_timing_p) // R4
        else $error("read answer not after exactly one wait state");

    write_gated_a: assert property (@(posedge hclk) disable iff (!hresetn) // R5
        vals.wr_en |-> timer_unit_enable[inst_q] && (state == DTR_BUS_WRITE))
        else $error("value write without unit enable");

    value_update_a: assert property (@(posedge hclk) disable iff (!hresetn) // R7
        vals.wr_en |=> vals.words[$past(vals.wr_idx)] == $past(hwdata[DTR_VAL_W-1:0]))
        else $error("enabled value write did not store data");

    // Word index held from the write cycle: a back-to-back transfer moves ofs_q
    disabled_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // R9
        (commit && is_value_slot(ofs_q) && !timer_unit_enable[inst_q]
            && !hw_load[vals.wr_idx])
            |=> vals.words[$past(vals.wr_idx)] == $past(wr_word_now))
        else $error("value changed by write while disabled");

    live_read_a: assert property (@(posedge hclk) disable iff (!hresetn) // R10
        (state == DTR_BUS_RDWAIT && hit_q && is_value_slot(ofs_q))
            |=> hrdata == 32'($past(rd_word_now)))
        else $error("value read not the count at access");

    reserved_zero_a: assert property (@(posedge hclk) disable iff (!hresetn) // R13
        (state == DTR_BUS_RDDONE && store_sel) |-> hrdata[31:DTR_VAL_W] == '0)
        else $error("reserved upper bits not zero");

    second_base_a: assert property (@(posedge hclk) disable iff (!hresetn) // R1
        (accept && in_window(haddr, SECOND_BASE)) |=> inst_q && hit_q == $past(decode_hit(haddr)))
        else $error("second instance not decoded");

    unmapped_zero_a: assert property (@(posedge hclk) disable iff (!hresetn) // R2
        (state == DTR_BUS_RDDONE && !hit_q) |-> hrdata == DTR_RDATA_NONE && !store_sel)
        else $error("unmapped read not zero");

    write_no_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (accept && hwrite) |=> hreadyout && hresp == DTR_HRESP_OKAY)
        else $error("write data phase stalled");

    first_base_a: assert property (@(posedge hclk) disable iff (!hresetn) // R1
        (accept && in_window(haddr, FIRST_BASE)) |=> !inst_q)
        else $error("first instance not decoded");

    // Config stores keep only the implemented low bits of the data phase word
    div_store_a: assert property (@(posedge hclk) disable iff (!hresetn) // R13
        (commit && ofs_q == DTR_OFS_DIV)
            |=> clock_divider[$past(inst_q)] == $past(hwdata[DTR_DIV_W-1:0]))
        else $error("divider write not stored");

    cksrc_store_a: assert property (@(posedge hclk) disable iff (!hresetn) // R13
        (commit && ofs_q == DTR_OFS_CKSRC)
            |=> clock_source_control[$past(inst_q)] == $past(hwdata[DTR_CKSRC_W-1:0]))
        else $error("clock source write not stored");

    mode_store_a: assert property (@(posedge hclk) disable iff (!hresetn) // R13
        (commit && ofs_q == DTR_OFS_MODE)
            |=> operating_mode_control[$past(inst_q)] == $past(hwdata[DTR_MODE_W-1:0]))
        else $error("mode write not stored");

    irqen_store_a: assert property (@(posedge hclk) disable iff (!hresetn) // R13
        (commit && ofs_q == DTR_OFS_IRQEN)
            |=> irq_enable_control[$past(inst_q)] == $past(hwdata[DTR_IRQEN_W-1:0]))
        else $error("interrupt enable write not stored");

    irqclr_store_a: assert property (@(posedge hclk) disable iff (!hresetn) // R13
        (commit && ofs_q == DTR_OFS_IRQCLR)
            |=> irq_flag_clear[$past(inst_q)] == $past(hwdata[DTR_IRQCLR_W-1:0]))
        else $error("interrupt clear write not stored");

    enable_follow_a: assert property (@(posedge hclk) disable iff (!hresetn) // R5
        (commit && ofs_q == DTR_OFS_MODE)
            |=> timer_unit_enable[$past(inst_q)] == $past(hwdata[DTR_MODE_EN_BIT]))
        else $error("unit enable not taken from mode write");

    cfg_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // R13
        !commit |=> $stable(clock_divider) && $stable(clock_source_control)
            && $stable(operating_mode_control) && $stable(irq_enable_control)
            && $stable(irq_flag_clear))
        else $error("configuration changed without a write");

    single_wait_a: assert property (@(posedge hclk) disable iff (!hresetn) // R4
        !hreadyout |=> hreadyout)
        else $error("read wait longer than one cycle");

    idle_rdata_a: assert property (@(posedge hclk) disable iff (!hresetn) // R13
        (state != DTR_BUS_RDDONE) |-> hrdata == DTR_RDATA_NONE)
        else $error("read data outside the read data cycle");

    div_read_a: assert property (@(posedge hclk) disable iff (!hresetn) // R2
        (state == DTR_BUS_RDWAIT && hit_q && ofs_q == DTR_OFS_DIV)
            |=> hrdata == 32'($past(clock_divider[inst_q])))
        else $error("divider read not the stored value");
endmodule

// File: verification/tb_dtr_timer_regs.sv
// Self-checking bench for the dual timer register front end over AHB-Lite
`timescale 1ns/1ps
module tb_dtr_timer_regs;
    import dtr_pkg::*;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    wire hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [DTR_WORDS-1:0] hw_load;
    logic [DTR_WORDS-1:0][DTR_VAL_W-1:0] hw_value;
    logic [DTR_WORDS-1:0][DTR_VAL_W-1:0] value_word;
    logic [DTR_INSTANCES-1:0] timer_unit_enable;
    logic [DTR_INSTANCES-1:0][DTR_DIV_W-1:0] div_out;
    logic [DTR_INSTANCES-1:0][DTR_CKSRC_W-1:0] cksrc_out;
    logic [DTR_INSTANCES-1:0][DTR_MODE_W-1:0] mode_out;
    logic [DTR_INSTANCES-1:0][DTR_IRQEN_W-1:0] irqen_out;
    logic [DTR_INSTANCES-1:0][DTR_IRQCLR_W-1:0] irqclr_out;
    logic [31:0] rd;
    logic [31:0] bases [DTR_INSTANCES];
    logic [15:0] exp_w [DTR_WORDS];
    int err_count;
    int checks;

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;

    dtr_timer_regs uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .hw_load(hw_load),
        .hw_value(hw_value), .value_word(value_word), .timer_unit_enable(timer_unit_enable),
        .clock_divider(div_out), .clock_source_control(cksrc_out),
        .operating_mode_control(mode_out), .irq_enable_control(irqen_out),
        .irq_flag_clear(irqclr_out)
    );

    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Ready is sampled at the falling edge, settled, ahead of the deciding rising edge
    task automatic wait_ready(output logic [31:0] q);
        int n;
        logic r;
        n = 0;
        r = 1'b0;
        while (r !== 1'b1) begin
            @(negedge hclk);
            r = hreadyout;
            q = hrdata;
            @(posedge hclk);
            n++;
            if (n > 50) begin
                err_count++;
                complete_run();
            end
        end
        check("hresp", {31'h0, hresp}, {31'h0, DTR_HRESP_OKAY});
    endtask

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= DTR_HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= 3'h2;
        wait_ready(rd);
        htrans <= 2'h0;
        hsel <= 1'b0;
        if (w) begin
            hwdata <= d;
        end
        wait_ready(rd);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdchk(input string name, input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(name, rd, exp);
    endtask

    // Reads every value slot of both instances and the stored words against exp_w
    task automatic check_values();
        for (int i = 0; i < DTR_INSTANCES; i++) begin
            for (int s = 0; s < DTR_SLOTS; s++) begin
                rdchk("value_read", bases[i] + 32'(4 * s), {16'h0, exp_w[i * DTR_SLOTS + s]});
                check("value_word", {16'h0, value_word[i * DTR_SLOTS + s]},
                    {16'h0, exp_w[i * DTR_SLOTS + s]});
            end
        end
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        hw_load = '0;
        hw_value = '0;
        err_count = 0;
        checks = 0;
        bases[0] = DTR_BASE_FIRST;
        bases[1] = DTR_BASE_SECOND;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < DTR_INSTANCES; i++) begin
            for (int o = 16; o <= 32; o += 4) begin
                rdchk("cfg_reset", bases[i] + 32'(o), 32'h0);
            end
        end
        // Values are undefined after power-up, so load known ones from the timer side
        for (int k = 0; k < DTR_WORDS; k++) begin
            hw_value[k] <= 16'h1000 + 16'(k);
            exp_w[k] = 16'h1000 + 16'(k);
        end
        hw_load <= {DTR_WORDS{1'b1}};
        @(posedge hclk);
        hw_load <= '0;
        @(posedge hclk);
        // Unit disabled: every value write must be dropped
        for (int i = 0; i < DTR_INSTANCES; i++) begin
            for (int s = 0; s < DTR_SLOTS; s++) begin
                wr(bases[i] + 32'(4 * s), 32'hffffabcd);
            end
        end
        check_values();
        // Enable the first instance only
        wr(bases[0] + 32'h18, 32'h1 << DTR_MODE_EN_BIT);
        @(negedge hclk);
        check("unit_enable", {30'h0, timer_unit_enable}, 32'h1);
        @(posedge hclk);
        rdchk("mode_read", bases[0] + 32'h18, 32'h1 << DTR_MODE_EN_BIT);
        for (int i = 0; i < DTR_INSTANCES; i++) begin
            for (int s = 0; s < DTR_SLOTS; s++) begin
                wr(bases[i] + 32'(4 * s), 32'h5a5a2000 + 32'(i * DTR_SLOTS + s));
                if (i == 0) begin
                    exp_w[s] = 16'h2000 + 16'(s);
                end
            end
        end
        check_values();
        // Stored widths of configuration registers, upper bits dropped
        wr(bases[1] + 32'h10, 32'hffffffff);
        rdchk("div_width", bases[1] + 32'h10, 32'(1 << DTR_DIV_W) - 32'h1);
        wr(bases[1] + 32'h14, 32'hffffffff);
        rdchk("cksrc_width", bases[1] + 32'h14, 32'(1 << DTR_CKSRC_W) - 32'h1);
        wr(bases[1] + 32'h18, 32'hffffffff);
        rdchk("mode_width", bases[1] + 32'h18, 32'(1 << DTR_MODE_W) - 32'h1);
        wr(bases[1] + 32'h1c, 32'hffffffff);
        rdchk("irqen_width", bases[1] + 32'h1c, 32'(1 << DTR_IRQEN_W) - 32'h1);
        wr(bases[1] + 32'h20, 32'hffffffff);
        rdchk("irqclr_width", bases[1] + 32'h20, 32'(1 << DTR_IRQCLR_W) - 32'h1);
        check("div_out", 32'(div_out[1]), 32'h000000ff);
        check("cksrc_out", 32'(cksrc_out[1]), 32'h0000003f);
        check("mode_out", 32'(mode_out[1]), 32'h000000ff);
        check("irqen_out", 32'(irqen_out[1]), 32'h000000ff);
        check("irqclr_out", 32'(irqclr_out[1]), 32'h000000ff);
        check("first_untouched", 32'(div_out[0]), 32'h0);
        check("both_enabled", {30'h0, timer_unit_enable}, 32'h3);
        // Second instance now enabled, so its capture B takes a write
        wr(bases[1] + 32'h08, 32'h00003333);
        exp_w[DTR_SLOTS + 2] = 16'h3333;
        rdchk("other_base", bases[0] + 32'h10, 32'h0);
        // Beyond the last register, and between the two windows
        wr(bases[0] + 32'h24, 32'hffffffff);
        rdchk("unmapped", bases[0] + 32'h24, 32'h0);
        rdchk("no_alias", bases[0] + 32'h40, 32'h0);
        // Live counts: the timer side moves both counters before the reads
        hw_value[0] <= 16'h7777;
        hw_value[3] <= 16'h8888;
        hw_load <= 8'h09;
        exp_w[0] = 16'h7777;
        exp_w[3] = 16'h8888;
        @(posedge hclk);
        hw_load <= '0;
        rdchk("cnt1_live", bases[0], 32'h00007777);
        rdchk("cnt2_live", bases[0] + 32'h0c, 32'h00008888);
        // Reset in mid-run keeps values but clears the enable
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check("enable_reset", {30'h0, timer_unit_enable}, 32'h0);
        check("irqclr_reset", 32'(irqclr_out[1]), 32'h0);
        rdchk("div_reset", bases[1] + 32'h10, 32'h0);
        wr(bases[0] + 32'h04, 32'h00004321);
        check_values();
        complete_run();
    end
endmodule
